// File: core/bus_fairness.v
// Purpose: arbitration fairness tracking and gating of own arbitration
// Assumes: bus pins are asynchronous, active high after receivers
// Notes: samples data lines from busy after bus free until select
`timescale 1ns/1ns
`include "bus_fairness_map.vh"

module bus_fairness
(
  // Clock and reset
  input wire CLK_I,
  input wire RESET_N_I,
  // Bus pins from receivers
  input wire BSY_I,
  input wire SEL_I,
  input wire RST_I,
  input wire [`ID_BITS-1:0] DATA_I,
  // Local configuration
  input wire [`ID_W-1:0] OWN_ID_I,
  input wire FAIR_EN_I,
  input wire [`ID_BITS-1:0] FAIR_MASK_I,
  // Local requests
  input wire NEED_I,
  input wire [`ID_BITS-1:0] DROP_ID_I,
  // Results of own arbitration
  input wire ARB_DONE_I,
  input wire ARB_WON_I,
  // Outputs
  output wire ARB_GO_O,
  output reg NONPART_O,
  output reg [`ID_BITS-1:0] FAIR_REG_O,
  output reg [`ID_BITS-1:0] SEEN_O
);

  //----------------------------------------
  // Input synchronisers
  //----------------------------------------
  reg [2:0] bsy_s;
  reg [2:0] sel_s;
  reg [2:0] rst_s;
  reg [`ID_BITS-1:0] d1;
  reg [`ID_BITS-1:0] d2;
  reg [`ID_BITS-1:0] d3;
  reg bsy;
  reg sel;
  reg brst;
  reg [`ID_BITS-1:0] data;

  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      bsy_s <= 3'h0;
      sel_s <= 3'h0;
      rst_s <= 3'h0;
      d1 <= 8'h00;
      d2 <= 8'h00;
      d3 <= 8'h00;
      bsy <= 1'b0;
      sel <= 1'b0;
      brst <= 1'b0;
      data <= 8'h00;
    end
    else
    begin
      bsy_s <= {bsy_s[1:0], BSY_I};
      sel_s <= {sel_s[1:0], SEL_I};
      rst_s <= {rst_s[1:0], RST_I};
      d1 <= DATA_I;
      d2 <= d1;
      d3 <= d2;
      if (bsy_s[1] == bsy_s[2])
        bsy <= bsy_s[2];
      if (sel_s[1] == sel_s[2])
        sel <= sel_s[2];
      if (rst_s[1] == rst_s[2])
        brst <= rst_s[2];
      if (d2 == d3)
        data <= d3;
    end
  end

  //----------------------------------------
  // Own-priority masks
  //----------------------------------------
  wire [`ID_BITS-1:0] own_bit;
  wire [`ID_BITS-1:0] lower_mask;
  wire [`ID_BITS-1:0] fair_bits;
  wire [`ID_BITS-1:0] win_bit;
  genvar g;

  assign own_bit = 8'h01 << OWN_ID_I;
  // Bits below own ID; higher IDs have higher priority
  assign lower_mask = own_bit - 8'h01;
  // Mask qualifies fairness; disable for a top initiator
  assign fair_bits = FAIR_EN_I ? (FAIR_REG_O & FAIR_MASK_I) : 8'h00;

  // Winner is the highest set ID seen: a bit wins when no higher bit is set
  generate
    for (g = 0; g < `ID_BITS; g = g + 1)
    begin : g_win
      wire [`ID_BITS-1:0] higher;
      assign higher = SEEN_O >> (g + 1);
      assign win_bit[g] = SEEN_O[g] & ~(|higher);
    end
  endgenerate

  //----------------------------------------
  // Arbitration window tracking
  //----------------------------------------
  localparam ST_FREE = 2'h0;
  localparam ST_WIN = 2'h1;
  localparam ST_HOLD = 2'h2;

  reg [1:0] state;
  reg bsy_d;
  reg win_end;
  reg win_start;
  // Window opens at busy after bus free, closes at select
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      state <= ST_FREE;
      bsy_d <= 1'b0;
      win_end <= 1'b0;
      win_start <= 1'b0;
      SEEN_O <= 8'h00;
    end
    else
    begin
      bsy_d <= bsy;
      win_end <= 1'b0;
      win_start <= 1'b0;
      case (state)
        ST_FREE:
        begin
          if (bsy && !bsy_d && !sel)
          begin
            state <= ST_WIN;
            win_start <= 1'b1;
            SEEN_O <= 8'h00;
          end
        end
        ST_WIN:
        begin
          // Continuous OR of every sample
          SEEN_O <= SEEN_O | data;
          if (sel)
          begin
            state <= ST_HOLD;
            win_end <= 1'b1;
          end
          else if (!bsy)
            state <= ST_FREE;
        end
        ST_HOLD:
        begin
          if (!bsy && !sel)
            state <= ST_FREE;
        end
        default:
          state <= ST_FREE;
      endcase
      if (brst)
        state <= ST_FREE;
    end
  end

  //----------------------------------------
  // Fairness register and lockout
  //----------------------------------------
  reg [`CNT_W-1:0] lock_cnt;
  reg arbing;
  reg [`ID_BITS-1:0] next_fair;
  wire lock_exp;
  wire [31:0] lock_full;
  wire [`CNT_W-1:0] lock_load;

  // Lockout reload, cut to the counter width on purpose
  assign lock_full = `LOCKOUT_CYC;
  assign lock_load = lock_full[`CNT_W-1:0];

  assign lock_exp = NONPART_O && (lock_cnt == 10'h001);
  // Arbitrate only with no pending lower losers
  // Level while allowed; a waiting nonparticipant never gets it
  assign ARB_GO_O = NEED_I && (fair_bits == 8'h00) && !NONPART_O && (state == ST_FREE);

  always @*
  begin
    next_fair = FAIR_REG_O;
    if (win_end && !NEED_I && !arbing)
      // Refresh with losers below own ID
      next_fair = SEEN_O & ~win_bit & ~own_bit & lower_mask;
    else if (win_end && NONPART_O)
      // Drop winner and absentees
      next_fair = FAIR_REG_O & SEEN_O & ~win_bit;
    else if (win_end && arbing && ARB_WON_I)
      // Keep lower losers after own win
      next_fair = SEEN_O & ~win_bit & ~own_bit & lower_mask;
    else if (win_end && arbing)
      // Lost to higher priority: clear to zero
      next_fair = 8'h00;
    // Frozen while needing except explicit removals
    next_fair = next_fair & ~DROP_ID_I;
    // Lockout with no arbitration clears all
    if (lock_exp)
      next_fair = 8'h00;
  end

  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      FAIR_REG_O <= `FAIR_RESET;
      NONPART_O <= 1'b0;
      lock_cnt <= 10'h000;
      arbing <= 1'b0;
    end
    else if (brst)
    begin
      // Bus reset clears fairness, lockout and arbitration state
      FAIR_REG_O <= `FAIR_RESET;
      NONPART_O <= 1'b0;
      lock_cnt <= 10'h000;
      arbing <= 1'b0;
    end
    else
    begin
      FAIR_REG_O <= next_fair;
      if (ARB_GO_O)
        arbing <= 1'b1;
      else if (ARB_DONE_I || win_end)
        arbing <= 1'b0;
      if (NEED_I && fair_bits != 8'h00 && !NONPART_O && !arbing)
      begin
        // Become nonparticipant and start lockout
        NONPART_O <= 1'b1;
        lock_cnt <= lock_load;
      end
      else if (NONPART_O)
      begin
        if (win_start)
          lock_cnt <= 10'h000;
        else if (lock_cnt > 10'h001)
          lock_cnt <= lock_cnt - 10'h001;
        if (lock_exp || !NEED_I)
          NONPART_O <= 1'b0;
        else if (win_end)
          // Re-evaluate at next decision point
          NONPART_O <= 1'b0;
      end
    end
  end

endmodule

// File: core/bus_fairness_map.vh
// Purpose: constants for the bus arbitration fairness block
// Assumes: 125 MHz clock, 8 ns period
// Notes: times in ns, cycle counts derived from them
`ifndef BUS_FAIRNESS_MAP_VH
`define BUS_FAIRNESS_MAP_VH

`define CLK_PERIOD_NS 8
// Data bus width used for arbitration, one bit per bus ID
`define ID_BITS 8
`define ID_W 3
`define FAIR_RESET 8'h00
// Window during which arbitration IDs stand on the bus
`define WIN_OPEN_NS 2800
`define WIN_CLOSE_NS 3600
// Lockout must exceed the select delay after busy
`define SEL_DELAY_NS 2400
`define ID_DRIVE_NS 1800
`define LOCKOUT_NS 3000
// Least times round up
`define WIN_OPEN_CYC ((`WIN_OPEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Longest time rounds down
`define WIN_CLOSE_CYC (`WIN_CLOSE_NS / `CLK_PERIOD_NS)
`define LOCKOUT_CYC ((`LOCKOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 10

`endif

// File: test/bus_fairness_properties.sv
// Purpose: port level checks on the fairness block
// Assumes: OWN_ID_I static, bus drops not issued mid window
// Notes: bound into every bus_fairness instance
`timescale 1ns/1ns
module bus_fairness_properties
(
  // Clock, reset and bus
  input wire CLK_I,
  input wire RESET_N_I,
  input wire RST_I,
  // Local side
  input wire [2:0] OWN_ID_I,
  input wire FAIR_EN_I,
  input wire [7:0] FAIR_MASK_I,
  input wire NEED_I,
  input wire ARB_GO_O,
  input wire NONPART_O,
  input wire [7:0] FAIR_REG_O,
  input wire [7:0] SEEN_O
);
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  property p_go_need;
    ARB_GO_O |-> NEED_I;
  endproperty
  a_go_need: assert property (p_go_need) else $error("go without need");
  property p_go_block;
    NEED_I && FAIR_EN_I && (FAIR_REG_O & FAIR_MASK_I) != 8'h00 |-> !ARB_GO_O;
  endproperty
  a_go_block: assert property (p_go_block) else $error("go while owed");
  property p_np_block;
    NONPART_O |-> !ARB_GO_O;
  endproperty
  a_np_block: assert property (p_np_block) else $error("go while waiting");
  property p_low_only;
    (FAIR_REG_O >> OWN_ID_I) == 8'h00;
  endproperty
  a_low_only: assert property (p_low_only) else $error("high id kept");
  property p_below_win;
    $changed(FAIR_REG_O) && FAIR_REG_O != 8'h00 |-> FAIR_REG_O < SEEN_O;
  endproperty
  a_below_win: assert property (p_below_win) else $error("winner kept");
  property p_frozen;
    NEED_I && FAIR_REG_O != 8'h00 |=> (FAIR_REG_O & ~$past(FAIR_REG_O)) == 8'h00;
  endproperty
  a_frozen: assert property (p_frozen) else $error("id added while frozen");
  property p_bus_rst;
    RST_I [*6] |=> FAIR_REG_O == 8'h00 && !NONPART_O;
  endproperty
  a_bus_rst: assert property (p_bus_rst) else $error("bus reset ignored");
  property p_np_rise;
    $rose(NONPART_O) |-> $past(FAIR_REG_O) != 8'h00;
  endproperty
  a_np_rise: assert property (p_np_rise) else $error("wait with empty reg");
endmodule
bind bus_fairness bus_fairness_properties chk_i (.*);

// File: test/bus_peer_model.sv
// Purpose: the other devices arbitrating on the bus
// Assumes: released lines read 0 through the terminators
// Notes: one arbitration per call, bus free afterwards
`timescale 1ns/1ns
module bus_peer_model
(
  // Bus lines
  input wire clk_i,
  output reg bsy_o = 1'b0,
  output reg sel_o = 1'b0,
  output reg rst_o = 1'b0,
  output reg [7:0] data_o = 8'h00
);
  task arb(input [7:0] ids, input [7:0] win);
  begin
    @(negedge clk_i) bsy_o = 1'b1;
    repeat (100) @(negedge clk_i);
    data_o = ids;
    repeat (300) @(negedge clk_i);
    sel_o = 1'b1;
    data_o = win;
    repeat (20) @(negedge clk_i);
    bsy_o = 1'b0;
    sel_o = 1'b0;
    data_o = 8'h00;
    repeat (50) @(negedge clk_i);
  end
  endtask
  task bus_rst;
  begin
    rst_o = 1'b1;
    repeat (10) @(negedge clk_i);
    rst_o = 1'b0;
    repeat (10) @(negedge clk_i);
  end
  endtask
endmodule

// File: test/parallel_bus_arbitration_fairness_tb.sv
// Purpose: scenario bench for the fairness block
// Assumes: own ID 4, the peer model makes all bus traffic
// Notes: own arbitration is shown by adding ID 4 to the peers
`timescale 1ns/1ns
module parallel_bus_arbitration_fairness_tb;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg need = 1'b0;
  reg fair_en = 1'b1;
  reg done = 1'b0;
  reg won = 1'b0;
  reg [7:0] mask = 8'hFF;
  reg [7:0] drop = 8'h00;
  wire bsy, sel, rst, go, np;
  wire [7:0] data, fr, seen;
  integer n_fail = 0;
  integer checks_done = 0;
  bus_peer_model peer (.clk_i(clk), .bsy_o(bsy), .sel_o(sel), .rst_o(rst), .data_o(data));
  bus_fairness uut (.CLK_I(clk), .RESET_N_I(reset_n), .BSY_I(bsy), .SEL_I(sel), .RST_I(rst),
    .DATA_I(data), .OWN_ID_I(3'h4), .FAIR_EN_I(fair_en), .FAIR_MASK_I(mask), .NEED_I(need),
    .DROP_ID_I(drop), .ARB_DONE_I(done), .ARB_WON_I(won), .ARB_GO_O(go), .NONPART_O(np),
    .FAIR_REG_O(fr), .SEEN_O(seen));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task chk(input [31:0] what, input [7:0] exp, input [7:0] got);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("unexpected %0s exp %h got %h", what, exp, got);
    end
  end
  endtask
  task conclude;
  begin
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task t_own(input [7:0] ids, input [7:0] win, input w);
  begin
    won = w;
    peer.arb(ids, win);
    need = 1'b0;
    done = 1'b1;
    @(negedge clk) done = 1'b0;
    won = 1'b0;
  end
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    chk("rst", 8'h00, fr);
    peer.arb(8'h45, 8'h40);
    chk("seen", 8'h45, seen);
    chk("fair", 8'h05, fr);
    $display("refresh test done");
    need = 1'b1;
    repeat (8) @(negedge clk);
    chk("go", 8'h00, {7'h00, go});
    chk("np", 8'h01, {7'h00, np});
    peer.arb(8'h06, 8'h04);
    chk("fair", 8'h00, fr);
    chk("np", 8'h00, {7'h00, np});
    chk("go", 8'h01, {7'h00, go});
    $display("postpone test done");
    t_own(8'h1A, 8'h10, 1'b1);
    chk("fair", 8'h0A, fr);
    $display("win test done");
    drop = 8'h02;
    repeat (4) @(negedge clk);
    drop = 8'h00;
    chk("fair", 8'h08, fr);
    mask = 8'hF7;
    need = 1'b1;
    repeat (4) @(negedge clk);
    chk("mask", 8'h01, {7'h00, go});
    mask = 8'hFF;
    fair_en = 1'b0;
    repeat (4) @(negedge clk);
    chk("off", 8'h01, {7'h00, go});
    need = 1'b0;
    fair_en = 1'b1;
    peer.bus_rst;
    chk("fair", 8'h00, fr);
    $display("drop test done");
    need = 1'b1;
    t_own(8'h92, 8'h80, 1'b0);
    chk("fair", 8'h00, fr);
    $display("loss test done");
    repeat (400) @(negedge clk);
    peer.arb(8'h45, 8'h40);
    need = 1'b1;
    repeat (300) @(negedge clk);
    chk("np", 8'h01, {7'h00, np});
    repeat (90) @(negedge clk);
    chk("np", 8'h00, {7'h00, np});
    chk("fair", 8'h00, fr);
    need = 1'b0;
    $display("lockout test done");
    conclude;
  end
  initial
  begin
    #200000;
    n_fail = n_fail + 1;
    conclude;
  end
endmodule
